// *** hdl/ofwm_pkg.sv ***
// Constants shared by the output frequency window monitor.
// Assumes a 100 MHz system clock and a word-aligned AHB-Lite register map.
package ofwm_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and window times
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned FAST_WIN_NS   = 10000;
	localparam int unsigned SLOW_WIN_NS   = 1000000;
	localparam int unsigned FAST_WIN_CYC  = FAST_WIN_NS / CLK_PERIOD_NS;
	localparam int unsigned SLOW_WIN_CYC  = SLOW_WIN_NS / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [11:0] OFS_LIMITS_LO = 12'h000;
	localparam logic [11:0] OFS_LIMITS_HI = 12'h004;
	localparam logic [11:0] OFS_FAST_WIN  = 12'h008;
	localparam logic [11:0] OFS_SLOW_WIN  = 12'h00c;
	localparam logic [11:0] OFS_STATUS    = 12'h010;
	localparam logic [11:0] OFS_EVENT     = 12'h014;
	localparam logic [11:0] OFS_MASK      = 12'h018;
	localparam logic [11:0] OFS_COUNT     = 12'h01c;

	////////////////////////////////////////////////////////////////////////////
	// Fields of the 64-bit limits register
	localparam int unsigned LIM_W        = 64;
	localparam int unsigned CNT_W        = 24;
	localparam int unsigned MIN_LSB      = 0;
	localparam int unsigned MAX_LSB      = 24;
	localparam int unsigned WIN_SEL_BIT  = 48;
	localparam int unsigned LIM_USED_W   = 49;
	localparam logic [63:0] LIMITS_RST   = 64'h0000_0000_0000_0000;
	localparam logic        WIN_SEL_FAST = 1'b0;
	localparam logic        WIN_SEL_SLOW = 1'b1;

	////////////////////////////////////////////////////////////////////////////
	// Status, event and mask layout
	localparam int unsigned EVT_OOR_BIT = 0;
	localparam logic [31:0] STATUS_RST  = 32'h0000_0000;
	localparam logic [31:0] MASK_RST    = 32'h0000_0000;

endpackage

// *** hdl/ofwm_window_timer.sv ***
// Window timer: one-cycle pulse at the end of each monitoring window.
// Assumes the length in system clock cycles is held stable by the caller.
`timescale 1ns/1ns
module ofwm_window_timer
	import ofwm_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Control
	input  wire logic        restart,
	input  wire logic [31:0] win_len,
	// Result
	output logic             win_end
);

	logic [31:0] cyc_r;
	logic [31:0] cyc_nxt;
	logic        last_w;

	// A length of zero behaves as one cycle
	assign cyc_nxt = cyc_r + 32'h0000_0001;
	assign last_w  = (cyc_nxt >= win_len);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cyc_r   <= 32'h0000_0000;
			win_end <= 1'b0;
		end else if (restart) begin
			cyc_r   <= 32'h0000_0000;
			win_end <= 1'b0;
		end else begin
			cyc_r   <= last_w ? 32'h0000_0000 : cyc_nxt;
			win_end <= last_w;
		end
	end

endmodule

// *** hdl/ofwm_edge_count.sv ***
// Edge counter: synchronises the monitored clock and counts its rising edges.
// Assumes the monitored clock is well below half the system clock rate.
`timescale 1ns/1ns
module ofwm_edge_count
	import ofwm_pkg::*;
#(
	parameter int unsigned W = CNT_W
) (
	// Clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// Monitored clock pin
	input  wire logic         mon_clk,
	// Window control
	input  wire logic         restart,
	input  wire logic         win_end,
	// Result
	output logic [W-1:0]      count_r,
	output logic              count_valid_r
);

	logic         sync1_r;
	logic         sync2_r;
	logic         prev_r;
	logic [W-1:0] acc_r;
	logic         rise_w;
	logic         sat_w;
	logic [W-1:0] acc_inc_w;

	assign rise_w    = sync2_r & ~prev_r;
	assign sat_w     = &acc_r;
	// Saturate rather than wrap so a wildly fast clock still reads as too high
	assign acc_inc_w = (rise_w && !sat_w) ? acc_r + W'(1) : acc_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r  <= 1'b0;
		end else begin
			sync1_r <= mon_clk;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_r         <= '0;
			count_r       <= '0;
			count_valid_r <= 1'b0;
		end else if (restart) begin
			acc_r         <= '0;
			count_valid_r <= 1'b0;
		end else if (win_end) begin
			acc_r         <= '0;
			count_r       <= acc_inc_w;
			count_valid_r <= 1'b1;
		end else begin
			acc_r         <= acc_inc_w;
			count_valid_r <= 1'b0;
		end
	end

endmodule

// *** hdl/ofwm_top.sv ***
// Output frequency window monitor with an AHB-Lite register slave.
// Assumes a single AHB-Lite master, word transfers, and hready fed back from
// hreadyout. The monitored clock arrives asynchronously on a pin.
//
// How it works
// RQ1 - Count above the upper limit at window end sets status and event.
// RQ2 - Count below the lower limit at window end sets status and event.
// RQ3 - Status stays set until a window count lies strictly between the limits.
// RQ4 - An upper limit of zero holds status low and stops new events; windows are still timed and counted.
// RQ5 - Window select bit 48 picks the short window at 0, long at 1.
// RQ6 - Software should pick the long window for clocks below 10 MHz.
// RQ7 - Event flag latches until cleared; each new out-of-range window sets it again.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
module ofwm_top
	import ofwm_pkg::*;
#(
	parameter int unsigned FAST_WIN_DEF = FAST_WIN_CYC,
	parameter int unsigned SLOW_WIN_DEF = SLOW_WIN_CYC
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Monitored clock
	input  wire logic        mon_clk,
	// Monitor results
	output logic             out_of_range_status,
	output logic             out_of_range_event,
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [LIM_W-1:0]  freq_monitor_limits_r;
	logic [31:0]       fast_win_r;
	logic [31:0]       slow_win_r;
	logic [31:0]       mask_r;
	logic              sts_r;
	logic              evt_r;
	logic              irq_r;
	logic [31:0]       rdata_r;

	// Write address phase held for the data phase
	logic              wr_pend_r;
	logic [11:0]       wr_ofs_r;

	////////////////////////////////////////////////////////////////////////////
	// Address decode
	logic              addr_ok_w;
	logic              rd_req_w;
	logic              wr_req_w;
	logic [11:0]       ofs_w;
	logic              ofs_hi_ok_w;

	assign ofs_w       = haddr[11:0];
	assign ofs_hi_ok_w = (haddr[31:12] == 20'h00000);
	assign addr_ok_w   = hsel & htrans[1] & hready;
	assign rd_req_w    = addr_ok_w & ~hwrite;
	assign wr_req_w    = addr_ok_w & hwrite & ofs_hi_ok_w;

	////////////////////////////////////////////////////////////////////////////
	// Data phase write strobes
	logic              wr_lo_w;
	logic              wr_hi_w;
	logic              wr_fast_w;
	logic              wr_slow_w;
	logic              wr_evt_w;
	logic              wr_mask_w;
	logic              restart_w;

	assign wr_lo_w   = wr_pend_r & (wr_ofs_r == OFS_LIMITS_LO);
	assign wr_hi_w   = wr_pend_r & (wr_ofs_r == OFS_LIMITS_HI);
	assign wr_fast_w = wr_pend_r & (wr_ofs_r == OFS_FAST_WIN);
	assign wr_slow_w = wr_pend_r & (wr_ofs_r == OFS_SLOW_WIN);
	assign wr_evt_w  = wr_pend_r & (wr_ofs_r == OFS_EVENT);
	assign wr_mask_w = wr_pend_r & (wr_ofs_r == OFS_MASK);
	// A window that straddles a configuration change would be judged against
	// mixed settings, so any limit or length write starts a fresh window
	assign restart_w = wr_lo_w | wr_hi_w | wr_fast_w | wr_slow_w;

	////////////////////////////////////////////////////////////////////////////
	// Limit fields
	logic [CNT_W-1:0]  min_lim_w;
	logic [CNT_W-1:0]  max_lim_w;
	logic              win_sel_w;
	logic              mon_en_w;
	logic [31:0]       win_len_w;

	assign min_lim_w = freq_monitor_limits_r[MIN_LSB +: CNT_W];
	assign max_lim_w = freq_monitor_limits_r[MAX_LSB +: CNT_W];
	assign win_sel_w = freq_monitor_limits_r[WIN_SEL_BIT];
	assign mon_en_w  = (max_lim_w != '0); // RQ4
	assign win_len_w = (win_sel_w == WIN_SEL_SLOW) ? slow_win_r : fast_win_r; // RQ5

	////////////////////////////////////////////////////////////////////////////
	// Window timing and edge counting
	logic              win_end_w;
	logic [CNT_W-1:0]  count_w;
	logic              count_valid_w;

	ofwm_window_timer u_timer (
		.hclk    (hclk),
		.hresetn (hresetn),
		.restart (restart_w),
		.win_len (win_len_w),
		.win_end (win_end_w)
	);

	ofwm_edge_count #(
		.W (CNT_W)
	) u_count (
		.hclk          (hclk),
		.hresetn       (hresetn),
		.mon_clk       (mon_clk),
		.restart       (restart_w),
		.win_end       (win_end_w),
		.count_r       (count_w),
		.count_valid_r (count_valid_w)
	);

	////////////////////////////////////////////////////////////////////////////
	// Window verdict
	logic              too_high_w;
	logic              too_low_w;
	logic              bad_w;
	logic              good_w;
	logic              evt_clr_w;
	logic              sts_nxt;
	logic              evt_nxt;
	logic              irq_nxt;

	assign too_high_w = (count_w > max_lim_w); // RQ1
	assign too_low_w  = (count_w < min_lim_w); // RQ2
	assign bad_w      = count_valid_w & mon_en_w & (too_high_w | too_low_w);
	// Equal to either limit neither sets nor clears the status
	assign good_w     = count_valid_w & (count_w < max_lim_w) & (count_w > min_lim_w); // RQ3
	assign evt_clr_w  = wr_evt_w & hwdata[EVT_OOR_BIT];

	// Status: disabled monitor forces it low, else sticky until a good window
	assign sts_nxt = !mon_en_w ? 1'b0 : bad_w ? 1'b1 : good_w ? 1'b0 : sts_r; // RQ1 RQ2 RQ3 RQ4
	// Event: a new bad window wins over a clear in the same cycle
	assign evt_nxt = bad_w ? 1'b1 : evt_clr_w ? 1'b0 : evt_r; // RQ7
	// Taken from the next event value so irq never trails the flag it reports
	assign irq_nxt = evt_nxt & mask_r[EVT_OOR_BIT];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sts_r <= STATUS_RST[EVT_OOR_BIT];
		end else begin
			sts_r <= sts_nxt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			evt_r <= STATUS_RST[EVT_OOR_BIT];
		end else begin
			evt_r <= evt_nxt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers
	logic [LIM_W-1:0]  lim_nxt;
	logic [31:0]       fast_win_nxt;
	logic [31:0]       slow_win_nxt;
	logic [31:0]       mask_nxt;

	// Reserved bits above the window select bit always hold zero
	assign lim_nxt = {{(LIM_W-LIM_USED_W){1'b0}},
		(wr_hi_w ? hwdata[LIM_USED_W-33:0] : freq_monitor_limits_r[LIM_USED_W-1:32]),
		(wr_lo_w ? hwdata : freq_monitor_limits_r[31:0])};
	assign fast_win_nxt = wr_fast_w ? hwdata : fast_win_r;
	assign slow_win_nxt = wr_slow_w ? hwdata : slow_win_r;
	// Only the one mask bit is kept; the rest read as zero
	assign mask_nxt     = wr_mask_w ? {31'h0000_0000, hwdata[EVT_OOR_BIT]} : mask_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			freq_monitor_limits_r <= LIMITS_RST;
		end else begin
			freq_monitor_limits_r <= lim_nxt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_win_r <= FAST_WIN_DEF;
		end else begin
			fast_win_r <= fast_win_nxt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slow_win_r <= SLOW_WIN_DEF;
		end else begin
			slow_win_r <= slow_win_nxt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_r <= MASK_RST;
		end else begin
			mask_r <= mask_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux, sampled in the address phase
	logic [31:0]       rd_mux_w;
	logic [31:0]       lim_hi_w;
	logic              rd_lo_w;
	logic              rd_hi_w;
	logic              rd_fast_w;
	logic              rd_slow_w;
	logic              rd_sts_w;
	logic              rd_evt_w;
	logic              rd_mask_w;
	logic              rd_cnt_w;

	assign lim_hi_w  = freq_monitor_limits_r[63:32];
	assign rd_lo_w   = ofs_hi_ok_w & (ofs_w == OFS_LIMITS_LO);
	assign rd_hi_w   = ofs_hi_ok_w & (ofs_w == OFS_LIMITS_HI);
	assign rd_fast_w = ofs_hi_ok_w & (ofs_w == OFS_FAST_WIN);
	assign rd_slow_w = ofs_hi_ok_w & (ofs_w == OFS_SLOW_WIN);
	assign rd_sts_w  = ofs_hi_ok_w & (ofs_w == OFS_STATUS);
	assign rd_evt_w  = ofs_hi_ok_w & (ofs_w == OFS_EVENT);
	assign rd_mask_w = ofs_hi_ok_w & (ofs_w == OFS_MASK);
	assign rd_cnt_w  = ofs_hi_ok_w & (ofs_w == OFS_COUNT);
	// Unmapped offsets select nothing and so read as zero
	assign rd_mux_w  = ({32{rd_lo_w}} & freq_monitor_limits_r[31:0])
		| ({32{rd_hi_w}} & lim_hi_w)
		| ({32{rd_fast_w}} & fast_win_r)
		| ({32{rd_slow_w}} & slow_win_r)
		| ({32{rd_sts_w}} & {31'h0000_0000, sts_r})
		| ({32{rd_evt_w}} & {31'h0000_0000, evt_r})
		| ({32{rd_mask_w}} & mask_r)
		| ({32{rd_cnt_w}} & {8'h00, count_w});

	////////////////////////////////////////////////////////////////////////////
	// Bus handshake: zero wait states, always OKAY
	logic [11:0]       wr_ofs_nxt;
	logic [31:0]       rdata_nxt;

	assign wr_ofs_nxt = wr_req_w ? ofs_w : wr_ofs_r;
	assign rdata_nxt  = rd_req_w ? rd_mux_w : rdata_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
		end else begin
			wr_pend_r <= wr_req_w;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ofs_r <= 12'h000;
		end else begin
			wr_ofs_r <= wr_ofs_nxt;
		end
	end

	// Read data stands until the next read address phase is taken
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign hrdata              = rdata_r;
	assign out_of_range_status = sts_r;
	assign out_of_range_event  = evt_r;
	assign irq                 = irq_r;

endmodule

// *** bench/ofwm_monitor.sv ***
// Checker for the frequency window monitor, bound to the top module.
// Assumes one bus master with hready fed back from hreadyout.
`timescale 1ns/1ns
module ofwm_checker
	import ofwm_pkg::*;
(
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Results
	input wire logic        out_of_range_status,
	input wire logic        out_of_range_event,
	input wire logic        irq
);
	logic        rd_q;
	logic        wr_q;
	logic        um_q;
	logic [11:0] a_q;
	wire         take = hsel & htrans[1] & hready;
	wire         um   = (haddr[31:12] != 20'h0) || (haddr[11:0] > OFS_COUNT);

	////////////////////////////////////////////////////////////////////////////
	// Data phase tracking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			um_q <= 1'b0;
			a_q  <= 12'h0;
		end else begin
			rd_q <= take & ~hwrite;
			wr_q <= take & hwrite;
			um_q <= um;
			a_q  <= haddr[11:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	bus_okay_a:
		assert property (hreadyout && !hresp) else $error("bus not ready or not OKAY");
	sts_sets_evt_a:
		assert property ($rose(out_of_range_status) |-> out_of_range_event)
		else $error("status rose without event");
	evt_needs_sts_a:
		assert property ($rose(out_of_range_event) |-> out_of_range_status)
		else $error("event rose without status");
	evt_clear_a:
		assert property ($fell(out_of_range_event) |->
			$past(wr_q && a_q == OFS_EVENT && hwdata[0])) else $error("event dropped alone");
	irq_cause_a:
		assert property (irq |-> out_of_range_event)
		else $error("irq without event");
	sts_read_a:
		assert property (rd_q && a_q == OFS_STATUS |->
			hrdata == {31'h0, $past(out_of_range_status)}) else $error("status read wrong");
	lim_rsvd_a:
		assert property (rd_q && a_q == OFS_LIMITS_HI |-> hrdata[31:17] == 15'h0)
		else $error("reserved limit bits set");
	unmapped_zero_a:
		assert property (rd_q && um_q |-> hrdata == 32'h0) else $error("unmapped read not 0");

	cover property ($rose(out_of_range_status));
	cover property ($fell(out_of_range_event));
	cover property ($rose(irq));
endmodule

// *** bench/ofwm_top_bench.sv ***
// Self-checking bench for the frequency window monitor.
// Short windows (20/50 cycles); the monitored clock runs at a quarter of hclk.
`timescale 1ns/1ns
module ofwm_top_bench;
	import ofwm_pkg::*;
	localparam int FW = 20;
	localparam int SW = 50;
	logic        hclk, hresetn, hsel, hwrite, mon_en, sts, evt, irq;
	logic        mon_clk = 1'b0;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0]  htrans;
	logic [1:0]  ph = 2'd0;
	logic        hreadyout, hresp;
	int          n_errors, comparisons, exp_sts, exp_evt, mask;

	ofwm_top #(.FAST_WIN_DEF(FW), .SLOW_WIN_DEF(SW)) u_ofwm_top (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .mon_clk(mon_clk),
		.out_of_range_status(sts), .out_of_range_event(evt), .irq(irq));

	initial hclk = 1'b0;
	always #5 hclk = ~hclk;
	// Quarter-rate clock keeps two hclk per level, well inside the synchroniser's reach
	always @(posedge hclk) begin
		ph <= ph + 2'd1;
		mon_clk <= mon_en & ph[1];
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {20'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic outs();
		chk("status", exp_sts, {31'h0, sts});
		chk("event", exp_evt, {31'h0, evt});
		chk("irq", exp_evt & mask, {31'h0, irq});
	endtask

	// Program limits, let three windows pass, then apply the model's verdict
	task automatic run(input int mn, input int mx, input bit sl, input bit on);
		int w;
		int c;
		w = sl ? SW : FW;
		c = on ? w / 4 : 0;
		mon_en <= on;
		bus(1'b1, OFS_LIMITS_LO, {mx[7:0], mn[23:0]});
		bus(1'b1, OFS_LIMITS_HI, {15'h0, sl, mx[23:8]});
		repeat (3 * w + 8) @(posedge hclk);
		if (mx == 0) exp_sts = 0;
		else if (c > mx || c < mn) begin
			exp_sts = 1;
			exp_evt = 1;
		end else if (c < mx && c > mn) exp_sts = 0;
		bus(1'b0, OFS_COUNT, 32'h0);
		if (q - c + 1 <= 2) q = c;
		chk("count", c, q);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk("status reg", exp_sts, q);
		outs();
	endtask

	task automatic print_verdict();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge hclk);
		n_errors++;
		print_verdict();
	end

	initial begin
		{hresetn, hsel, hwrite, mon_en} = '0;
		{haddr, hwdata, htrans, exp_sts, exp_evt, mask} = '0;
		void'($urandom(14401));
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, OFS_LIMITS_LO, 32'h0);
		chk("limits lo", 32'h0, q);
		bus(1'b0, OFS_LIMITS_HI, 32'h0);
		chk("limits hi", 32'h0, q);
		bus(1'b0, OFS_MASK, 32'h0);
		chk("mask", 32'h0, q);
		bus(1'b0, OFS_FAST_WIN, 32'h0);
		chk("fast win", FW, q);
		bus(1'b0, OFS_SLOW_WIN, 32'h0);
		chk("slow win", SW, q);
		bus(1'b0, 12'h020, 32'h0);
		chk("unmapped", 32'h0, q);
		bus(1'b1, OFS_LIMITS_HI, 32'hffff_ffff);
		bus(1'b0, OFS_LIMITS_HI, 32'h0);
		chk("limits hi rsvd", 32'h0001_ffff, q);
		run(1 + $urandom % 1000, 0, 0, 0);
		run(1 + $urandom % 1000, 24'hffffff, 0, 0);
		run(1, 20 + $urandom % 100, 0, 1);
		bus(1'b1, OFS_MASK, 32'h1);
		mask = 1;
		repeat (3) @(posedge hclk);
		outs();
		bus(1'b1, OFS_EVENT, 32'h1);
		exp_evt = 0;
		repeat (3) @(posedge hclk);
		outs();
		run(1, 2, 1, 1);
		run(1, 100 + $urandom % 100, 1, 1);
		run(20, 24'hffffff, 1, 1);
		run(20, 0, 1, 1);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		{exp_sts, exp_evt, mask} = '0;
		outs();
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, OFS_LIMITS_HI, 32'h0);
		chk("limits hi after reset", 32'h0, q);
		outs();
		print_verdict();
	end
endmodule

bind ofwm_top ofwm_checker u_ofwm_checker (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .hrdata, .hreadyout, .hresp, .out_of_range_status,
	.out_of_range_event, .irq);
